/* File: src/msac_pkg.sv */
// Package for the control-store access block: address map, status codes,
// mode encoding and timing constants.
// Assumes a 16-bit byte-addressed control-store space on a 125 MHz clock.
package msac_pkg;

  // Address map of the control-store space
  localparam logic [15:0] MSAC_RAM_LO   = 16'h0000; // Workspace store start
  localparam logic [15:0] MSAC_RAM_HI   = 16'h001e; // Workspace store end
  localparam logic [15:0] MSAC_ROM_LO   = 16'h0800; // On-chip ROM start
  localparam logic [15:0] MSAC_ROM_HI   = 16'h0bfe; // On-chip ROM end
  localparam logic [15:0] MSAC_PROTO_HI = 16'h0ffe; // Redirected range end
  localparam logic [15:0] MSAC_EXT_LO   = 16'h1000; // External range start
  localparam logic [15:0] MSAC_EXT_HI   = 16'hfffe; // External range end

  // Store sizes
  localparam int MSAC_ROM_BYTES = 1024; // On-chip ROM bytes
  localparam int MSAC_RAM_BYTES = 32;   // On-chip RAM bytes
  localparam int MSAC_ROM_WORDS = MSAC_ROM_BYTES / 2;
  localparam int MSAC_RAM_WORDS = MSAC_RAM_BYTES / 2;

  // Bus status codes (4-bit field)
  localparam logic [3:0] MSAC_BST_IDLE   = 4'h0; // No bus activity
  localparam logic [3:0] MSAC_BST_CS     = 4'hc; // Plain control-store code
  localparam logic [3:0] MSAC_BST_CS_LCK = 4'hd; // Locked control-store code
  localparam logic [3:0] MSAC_BST_MEM    = 4'h8; // Main memory code

  // Interrupt level raised on an undefined opcode in baseline mode
  localparam logic [3:0] MSAC_TRAP_LEVEL = 4'h2;

  // Wait-state bound before a stuck ready is reported (debug aid)
  localparam int MSAC_READY_TMO_NS  = 2000;
  localparam int MSAC_CLK_PERIOD_NS = 8;
  localparam int MSAC_READY_TMO_CYC = MSAC_READY_TMO_NS / MSAC_CLK_PERIOD_NS;

  // Operating modes, Gray along baseline -> prototyping
  typedef enum logic [1:0] {
    MSAC_MODE_BASE  = 2'b00,
    MSAC_MODE_PROTO = 2'b01,
    MSAC_MODE_STD   = 2'b11
  } msac_mode_t;

  // Access target after decode
  typedef enum logic [1:0] {
    MSAC_TGT_NONE = 2'b00,
    MSAC_TGT_RAM  = 2'b01,
    MSAC_TGT_ROM  = 2'b11,
    MSAC_TGT_EXT  = 2'b10
  } msac_tgt_t;

  // Cycle state machine, Gray along idle -> ext -> wait
  typedef enum logic [1:0] {
    MSAC_ST_IDLE = 2'b00,
    MSAC_ST_EXT  = 2'b01,
    MSAC_ST_WAIT = 2'b11
  } msac_state_t;

  // Core-side access request
  typedef struct packed {
    logic        valid;   // Request present
    logic        write;   // 1 write, 0 read
    logic        locked;  // Locked instruction in progress
    logic [15:0] addr;    // Byte address
    logic [15:0] wdata;   // Write data
  } msac_req_t;

  // Core-side answer
  typedef struct packed {
    logic        done;    // Access completed this cycle
    logic        fault;   // Access refused (space disabled or address unmapped)
    logic [15:0] rdata;   // Read data
  } msac_rsp_t;

  // External bus outputs
  typedef struct packed {
    logic        rd_n;    // Read strobe, low active
    logic        wr_n;    // Write strobe, low active
    logic [3:0]  bst;     // Bus status code
    logic [15:0] addr;    // Address
    logic [15:0] wdata;   // Write data
    logic        dout_en; // Data bus drive enable
  } msac_bus_t;

endpackage : msac_pkg

/* File: src/msac_mode_sel.sv */
// Operating-mode selector for the control-store access block.
// Assumes resetn is the chip reset and the presence pin is asynchronous.
`timescale 1ns/1ps
module msac_mode_sel (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              attached_proc_present_n,
  output msac_pkg::msac_mode_t   mode,
  output logic                   mode_valid
);
  import msac_pkg::*;

  logic       sync1_q;      // First synchroniser stage
  logic       sync2_q;      // Second synchroniser stage
  logic       low_rst_q;    // Pin seen low while in reset
  logic       low_rst_d;
  logic       first_q;      // Still at first cycle after release
  logic       first_d;
  logic       settle_q;     // Release value has reached the second stage
  logic       settle_d;
  msac_mode_t mode_q;       // Latched mode
  msac_mode_t mode_d;
  logic       valid_q;      // Mode latched
  logic       valid_d;

  // Two-flop synchroniser for the pin; no reset, so that it keeps
  // following the pin while reset is held
  always_ff @(posedge sys_clk) begin
    sync1_q <= attached_proc_present_n;
    sync2_q <= sync1_q;
  end

  // Next mode. The pin level under reset is caught in the first cycle after
  // release; one settle cycle lets the post-release level reach stage two:
  // low pin that rises with reset gives prototyping, one that stays low
  // gives baseline.
  always_comb begin
    low_rst_d = low_rst_q;
    first_d   = first_q;
    settle_d  = settle_q;
    mode_d    = mode_q;
    valid_d   = valid_q;
    if (first_q) begin
      // Catch pin right after release
      low_rst_d = ~sync2_q;
      first_d   = 1'b0;
    end else if (!valid_q && !settle_q) begin
      // Wait for the released pin level
      settle_d = 1'b1;
    end else if (!valid_q) begin
      // Third cycle: decide
      valid_d = 1'b1;
      if (!low_rst_q)
        mode_d = MSAC_MODE_STD;
      else if (sync2_q)
        mode_d = MSAC_MODE_PROTO;
      else
        mode_d = MSAC_MODE_BASE;
    end else if (mode_q == MSAC_MODE_BASE && sync2_q) begin
      // Pin rose later: leave baseline
      mode_d = MSAC_MODE_PROTO;
    end
    // Otherwise mode holds until the next reset
  end

  // Register stage only
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      low_rst_q <= 1'b0;
      first_q   <= 1'b1;
      settle_q  <= 1'b0;
      mode_q    <= MSAC_MODE_BASE;
      valid_q   <= 1'b0;
    end else begin
      low_rst_q <= low_rst_d;
      first_q   <= first_d;
      settle_q  <= settle_d;
      mode_q    <= mode_d;
      valid_q   <= valid_d;
    end
  end

  assign mode       = mode_q;
  assign mode_valid = valid_q;

endmodule : msac_mode_sel

/* File: src/msac_access_ctrl.sv */
// Control-store access controller: decodes, serves on-chip stores and runs
// external cycles with ready wait states.
// Assumes the core issues one request at a time and holds it until done.
//
// Function
// - Separate 64 KB control-store address space
// - 1024-byte ROM, 32-byte RAM on chip
// - On-chip accesses finish in one state
// - 0x0800 to 0x0BFE decode to ROM
// - 0x0000 to 0x001E decode to RAM
// - 0x1000 upward external, strobe per direction
// - External cycles: memory timing, store codes
// - Locked code for locking instructions
// - On-chip accesses: codes out, strobes high
// - Page select inverts bit, unless override
// - Pin high at reset: standard
// - Pin low with reset: prototyping
// - Prototyping sends ROM range outside
// - Pin tied low: baseline
// - Baseline disables store and interface
// - Force privileged while in store
// - Baseline trap: flag, level 2 one cycle later
// - Pin rising in baseline: prototyping
`timescale 1ns/1ps
module msac_access_ctrl #(
  parameter int ROM_WORDS = msac_pkg::MSAC_ROM_WORDS,
  parameter int RAM_WORDS = msac_pkg::MSAC_RAM_WORDS
) (
  input  wire logic               sys_clk,
  input  wire logic               resetn,
  input  msac_pkg::msac_req_t     req,
  output msac_pkg::msac_rsp_t     rsp,
  input  wire logic               in_ctrl_store,
  input  wire logic               mem_cycle,
  input  wire logic               page_status_bit,
  input  wire logic               long_source_override,
  input  wire logic               long_dest_override,
  input  wire logic               undef_opcode,
  input  wire logic               ready,
  input  wire logic [15:0]        ext_rdata,
  input  wire logic               attached_proc_present_n,
  output msac_pkg::msac_bus_t     bus,
  output logic                    page_select_n,
  output logic                    force_privileged,
  output logic                    illegal_op_flag,
  output logic                    trap_req,
  output logic [3:0]              trap_level,
  output logic                    ap_if_enable,
  output msac_pkg::msac_mode_t    mode
);
  import msac_pkg::*;

  // On-chip stores: ROM contents come from a constant init, RAM is workspace
  logic [15:0] rom_mem [ROM_WORDS];
  logic [15:0] ram_mem [RAM_WORDS];

  logic        mode_valid;                   // Mode latched
  msac_tgt_t   tgt;                          // Decoded target
  logic        ready_s1_q;                   // Ready sync stage 1
  logic        ready_s2_q;                   // Ready sync stage 2
  msac_state_t st_q;                         // Cycle state
  msac_state_t st_d;
  msac_bus_t   bus_q;                        // Registered bus outputs
  msac_bus_t   bus_d;
  msac_rsp_t   rsp_q;                        // Registered answer
  msac_rsp_t   rsp_d;
  logic        psel_q;                       // Page select
  logic        psel_d;
  logic        illegal_op_flag_q;                      // Illegal-op flag
  logic        illegal_op_flag_d;
  logic        trap_q;                       // Trap pulse
  logic        trap_d;
  logic        ext_cnt_q;                    // Second strobe state reached
  logic        ext_cnt_d;
  logic [3:0]  code_d;                       // Code of current request
  logic [$clog2(ROM_WORDS)-1:0] rom_idx;     // ROM word index
  logic [$clog2(RAM_WORDS)-1:0] ram_idx;     // RAM word index

  // Mode selection at reset release
  msac_mode_sel u_mode (
    .sys_clk                 (sys_clk),
    .resetn                  (resetn),
    .attached_proc_present_n (attached_proc_present_n),
    .mode                    (mode),
    .mode_valid              (mode_valid)
  );

  // ROM image: a neutral pattern, replaced by real firmware at build time
  generate
    for (genvar i = 0; i < ROM_WORDS; i++) begin : g_rom
      assign rom_mem[i] = 16'(i);
    end
  endgenerate

  assign rom_idx = req.addr[$clog2(ROM_WORDS):1];
  assign ram_idx = req.addr[$clog2(RAM_WORDS):1];

  // Address decode per mode; the full 16-bit space is its own space
  always_comb begin
    tgt = MSAC_TGT_NONE;
    if (mode_valid && mode != MSAC_MODE_BASE) begin
      if (req.addr <= MSAC_RAM_HI)
        tgt = MSAC_TGT_RAM;
      else if (req.addr >= MSAC_EXT_LO)
        tgt = MSAC_TGT_EXT;
      else if (req.addr >= MSAC_ROM_LO && mode == MSAC_MODE_PROTO)
        tgt = MSAC_TGT_EXT;
      else if (req.addr >= MSAC_ROM_LO && req.addr <= MSAC_ROM_HI)
        tgt = MSAC_TGT_ROM;
    end
  end

  // Ready is a pin: two flops before use
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ready_s1_q <= 1'b1;
      ready_s2_q <= 1'b1;
    end else begin
      ready_s1_q <= ready;
      ready_s2_q <= ready_s1_q;
    end
  end

  // Locked code for locking instructions, plain code otherwise
  assign code_d = req.locked ? MSAC_BST_CS_LCK : MSAC_BST_CS;

  // Cycle engine next state
  always_comb begin
    st_d        = st_q;
    bus_d       = bus_q;
    rsp_d       = '0;
    ext_cnt_d   = 1'b0;
    case (st_q)
      MSAC_ST_IDLE: begin
        bus_d.rd_n    = 1'b1;
        bus_d.wr_n    = 1'b1;
        bus_d.dout_en = 1'b0;
        bus_d.bst     = mem_cycle ? MSAC_BST_MEM : MSAC_BST_IDLE;
        if (req.valid && !rsp_q.done) begin
          case (tgt)
            MSAC_TGT_RAM, MSAC_TGT_ROM: begin
              // One state, codes out, strobes stay high
              bus_d.bst  = code_d;
              rsp_d.done = 1'b1;
              rsp_d.rdata = (tgt == MSAC_TGT_RAM) ?
                            ram_mem[ram_idx] : rom_mem[rom_idx];
            end
            MSAC_TGT_EXT: begin
              // External cycle with memory timing
              bus_d.bst     = code_d;
              bus_d.addr    = req.addr;
              bus_d.wdata   = req.wdata;
              bus_d.rd_n    = req.write;
              bus_d.wr_n    = ~req.write;
              bus_d.dout_en = req.write;
              st_d          = MSAC_ST_EXT;
            end
            default: begin
              // Space disabled or address unmapped: refuse at once
              rsp_d.done  = 1'b1;
              rsp_d.fault = 1'b1;
            end
          endcase
        end
      end
      MSAC_ST_EXT: begin
        // Two states, so the synchronised ready reflects the strobe
        // and not the stale idle level
        if (ext_cnt_q)
          st_d = MSAC_ST_WAIT;
        else
          ext_cnt_d = 1'b1;
      end
      MSAC_ST_WAIT: begin
        // Ready low stretches the cycle
        if (ready_s2_q) begin
          rsp_d.done    = 1'b1;
          rsp_d.rdata   = ext_rdata;
          bus_d.rd_n    = 1'b1;
          bus_d.wr_n    = 1'b1;
          bus_d.dout_en = 1'b0;
          bus_d.bst     = MSAC_BST_IDLE;
          st_d          = MSAC_ST_IDLE;
        end
      end
      default: st_d = MSAC_ST_IDLE;
    endcase
  end

  // Page select: undefined in store cycles, so it simply holds there
  always_comb begin
    psel_d = psel_q;
    if (mem_cycle && !in_ctrl_store) begin
      if (long_source_override || long_dest_override)
        psel_d = page_status_bit;
      else
        psel_d = ~page_status_bit;
    end
  end

  // Baseline trap; set wins, flag is cleared only by reset here
  always_comb begin
    illegal_op_flag_d = illegal_op_flag_q;
    trap_d  = 1'b0;
    if (mode_valid && mode == MSAC_MODE_BASE && undef_opcode) begin
      illegal_op_flag_d = 1'b1;
      trap_d  = 1'b1;
    end
  end

  // Register stage
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_q    <= MSAC_ST_IDLE;
      bus_q   <= '{rd_n: 1'b1, wr_n: 1'b1, bst: MSAC_BST_IDLE,
                   addr: 16'h0000, wdata: 16'h0000, dout_en: 1'b0};
      rsp_q   <= '0;
      psel_q  <= 1'b1;
      illegal_op_flag_q <= 1'b0;
      trap_q  <= 1'b0;
      ext_cnt_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      bus_q   <= bus_d;
      rsp_q   <= rsp_d;
      psel_q  <= psel_d;
      illegal_op_flag_q <= illegal_op_flag_d;
      trap_q  <= trap_d;
      ext_cnt_q <= ext_cnt_d;
    end
  end

  // Workspace RAM write in one state
  always_ff @(posedge sys_clk) begin
    if (st_q == MSAC_ST_IDLE && req.valid && !rsp_q.done &&
        req.write && tgt == MSAC_TGT_RAM)
      ram_mem[ram_idx] <= req.wdata;
  end

  assign bus              = bus_q;
  assign rsp              = rsp_q;
  assign page_select_n    = psel_q;
  assign force_privileged = in_ctrl_store;
  assign illegal_op_flag  = illegal_op_flag_q;
  assign trap_req         = trap_q;
  assign trap_level       = MSAC_TRAP_LEVEL;
  assign ap_if_enable     = mode_valid && mode != MSAC_MODE_BASE;

endmodule : msac_access_ctrl

/* File: tb/msac_asserts.sv */
// Checker for the control-store access controller.
// Sees only the top module's ports; attached by the bind at the foot.
`timescale 1ns/1ps
module msac_asserts (
  input wire logic            sys_clk,
  input wire logic            resetn,
  input msac_pkg::msac_req_t  req,
  input msac_pkg::msac_rsp_t  rsp,
  input wire logic            in_ctrl_store,
  input wire logic            mem_cycle,
  input wire logic            page_status_bit,
  input wire logic            long_source_override,
  input wire logic            long_dest_override,
  input wire logic            undef_opcode,
  input wire logic            ready,
  input msac_pkg::msac_bus_t  bus,
  input logic                 page_select_n,
  input logic                 force_privileged,
  input logic                 illegal_op_flag,
  input logic                 trap_req,
  input logic [3:0]           trap_level,
  input logic                 ap_if_enable,
  input msac_pkg::msac_mode_t mode
);
  import msac_pkg::*;
  logic ram_hit; // Workspace store range
  logic rom_hit; // On-chip ROM range
  logic ext_hit; // Goes off chip in this mode
  logic strobe;  // Either strobe active
  logic live;    // Store enabled at all

  // Decode helpers, recomputed from the request, the mode and the bus strobes
  always_comb begin
    ram_hit = req.addr <= MSAC_RAM_HI;
    rom_hit = req.addr >= MSAC_ROM_LO && req.addr <= MSAC_ROM_HI;
    ext_hit = req.addr >= MSAC_EXT_LO || (mode == MSAC_MODE_PROTO &&
              req.addr >= MSAC_ROM_LO && req.addr <= MSAC_PROTO_HI);
    strobe  = !(bus.rd_n && bus.wr_n);
    live    = mode != MSAC_MODE_BASE;
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  AST_RAM_ONE: assert property ($rose(req.valid) && ram_hit && live |=>
    rsp.done && !rsp.fault) else $error("workspace access not in one cycle");
  AST_ROM_STD: assert property ($rose(req.valid) && rom_hit &&
    mode == MSAC_MODE_STD |=> rsp.done && !rsp.fault)
    else $error("rom access not served on chip");
  AST_QUIET: assert property ($rose(req.valid) && (ram_hit || rom_hit) &&
    mode == MSAC_MODE_STD |-> (bus.rd_n && bus.wr_n) [*3])
    else $error("strobe active on on-chip access");
  AST_EXT_DIR: assert property ($rose(req.valid) && ext_hit && live |=>
    bus.rd_n == req.write && bus.wr_n == !req.write)
    else $error("wrong strobe on external cycle");
  AST_CODE: assert property (strobe |-> bus.bst ==
    (req.locked ? MSAC_BST_CS_LCK : MSAC_BST_CS))
    else $error("wrong status code on external cycle");
  AST_WAIT: assert property ((!bus.rd_n && !ready) [*3] |=> !rsp.done)
    else $error("read finished while ready low");
  AST_PAGE: assert property (mem_cycle && !in_ctrl_store |=>
    page_select_n ==
    ($past(page_status_bit) ^ !($past(long_source_override) ||
    $past(long_dest_override)))) else $error("page select wrong");
  AST_BASE: assert property ($rose(req.valid) && !live |=>
    rsp.done && rsp.fault) else $error("baseline access not refused");
  AST_APIF: assert property (ap_if_enable == live)
    else $error("interface enable disagrees with mode");
  AST_TRAP: assert property (undef_opcode && !live |=> trap_req &&
    illegal_op_flag && trap_level == 4'h2) else $error("trap not raised");
  AST_PRIV: assert property (force_privileged == in_ctrl_store)
    else $error("privilege not forced");
  AST_KEEP: assert property (live |=> mode == $past(mode))
    else $error("mode changed without reset");

  // Main scenarios reached
  cover property ($rose(req.valid) && ext_hit && live);
  cover property (!bus.rd_n && !ready);
  cover property (trap_req);
endmodule : msac_asserts

bind msac_access_ctrl msac_asserts u_asserts (.sys_clk, .resetn, .req,
  .rsp, .in_ctrl_store, .mem_cycle, .page_status_bit,
  .long_source_override, .long_dest_override, .undef_opcode, .ready, .bus,
  .page_select_n, .force_privileged, .illegal_op_flag, .trap_req,
  .trap_level, .ap_if_enable, .mode);

/* File: tb/msac_ext_mem.sv */
// Off-chip control-store memory with board decode and wait logic.
// Assumes bus outputs are registered; 16 words, aliased on addr[4:1].
`timescale 1ns/1ps
module msac_ext_mem (
  input wire logic           sys_clk,
  input msac_pkg::msac_bus_t bus,
  input wire logic [3:0]     wait_n,
  output logic               ready,
  output logic [15:0]        ext_rdata
);
  import msac_pkg::*;
  logic [15:0] mem_q [16];     // Storage
  logic [3:0]  cnt_q;          // Wait states left
  logic        act_q = 1'b0;   // Cycle seen last clock
  logic [15:0] last_q = 16'h0; // Last word driven
  logic        sel;            // Board select

  // Code plus strobe picks our cycles; page select is never used
  assign sel = (bus.bst == MSAC_BST_CS || bus.bst == MSAC_BST_CS_LCK) &&
               !(bus.rd_n && bus.wr_n);

  // Ready held low for the requested waits, high when idle
  assign ready = !sel || (act_q ? cnt_q == 4'h0 : wait_n == 4'h0);

  // Released data lines show the inverse, not the stale word
  assign ext_rdata = (sel && !bus.rd_n) ? mem_q[bus.addr[4:1]] : ~last_q;

  // Wait counter and storage
  always_ff @(posedge sys_clk) begin
    act_q <= sel;
    if (sel && !act_q) begin
      cnt_q <= wait_n;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
    if (sel && !bus.wr_n) begin
      mem_q[bus.addr[4:1]] <= bus.wdata;
    end
    if (sel && !bus.rd_n) begin
      last_q <= mem_q[bus.addr[4:1]];
    end
  end
endmodule : msac_ext_mem

/* File: tb/msac_access_ctrl_tb.sv */
// Self-checking bench for the control-store access controller.
// Assumes the external memory model answers every off-chip cycle.
`timescale 1ns/1ps
module msac_access_ctrl_tb;
  import msac_pkg::*;
  logic sys_clk, resetn, in_ctrl_store, mem_cycle, page_status_bit;
  logic long_source_override, long_dest_override, undef_opcode, ready;
  logic attached_proc_present_n, page_select_n, force_privileged;
  logic illegal_op_flag, trap_req, ap_if_enable;
  logic [15:0] ext_rdata;
  logic [3:0]  trap_level, wait_n;
  msac_req_t   req;
  msac_rsp_t   rsp;
  msac_bus_t   bus;
  msac_mode_t  mode;
  int          num_errors = 0;
  int          compares = 0;

  msac_access_ctrl u_dut (.sys_clk, .resetn, .req, .rsp, .in_ctrl_store,
    .mem_cycle, .page_status_bit, .long_source_override,
    .long_dest_override, .undef_opcode, .ready, .ext_rdata,
    .attached_proc_present_n, .bus, .page_select_n, .force_privileged,
    .illegal_op_flag, .trap_req, .trap_level, .ap_if_enable, .mode);
  msac_ext_mem u_mem (.sys_clk, .bus, .wait_n, .ready, .ext_rdata);

  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One core request, held until done, dropped just after it
  task automatic acc(input logic w, lk, input logic [15:0] a, d,
                     output logic [15:0] rd, output logic f, output int n);
    @(posedge sys_clk);
    #1 req = '{1'b1, w, lk, a, d};
    n = 0;
    do begin
      @(posedge sys_clk);
      #1 n++;
    end while (rsp.done !== 1'b1 && n < 60);
    rd = rsp.rdata;
    f = rsp.fault;
    req.valid = 1'b0;
    check("done", 16'(rsp.done), 16'h1);
  endtask : acc

  // Reset 20 cycles with the presence pin set for a mode
  task automatic do_reset(input logic p_rst, p_rel, input msac_mode_t exp);
    @(posedge sys_clk);
    #1 resetn = 1'b0;
    attached_proc_present_n = p_rst;
    repeat (20) @(posedge sys_clk);
    #1 resetn = 1'b1;
    attached_proc_present_n = p_rel;
    repeat (5) @(posedge sys_clk);
    #1 check("mode", 16'(mode), 16'(exp));
    check("ap_if", 16'(ap_if_enable), 16'(exp != MSAC_MODE_BASE));
  endtask : do_reset

  task automatic t_std;
    logic [15:0] rd;
    logic f;
    int n;
    do_reset(1'b1, 1'b1, MSAC_MODE_STD);
    acc(1'b1, 1'b0, 16'h001e, 16'ha5c3, rd, f, n);
    check("ram_lat", 16'(n), 16'h1);
    acc(1'b0, 1'b0, 16'h001e, 16'h0, rd, f, n);
    check("ram_rd", rd, 16'ha5c3);
    acc(1'b0, 1'b0, 16'h0bfe, 16'h0, rd, f, n);
    check("rom_rd", rd, 16'h01ff);
    acc(1'b0, 1'b0, 16'h0020, 16'h0, rd, f, n);
    check("gap_flt", 16'(f), 16'h1);
    acc(1'b0, 1'b0, 16'h0c00, 16'h0, rd, f, n);
    check("hole_flt", 16'(f), 16'h1);
    wait_n = 4'h0;
    acc(1'b1, 1'b0, 16'hfffe, 16'h1234, rd, f, n);
    check("ext_flt", 16'(f), 16'h0);
    wait_n = 4'h3;
    acc(1'b0, 1'b1, 16'hfffe, 16'h0, rd, f, n);
    check("ext_rd", rd, 16'h1234);
    check("waits", 16'(n > 5), 16'h1);
  endtask : t_std

  task automatic t_page;
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      #1 mem_cycle = 1'b1;
      page_status_bit = i[0];
      long_source_override = (i[2:1] == 2'd1);
      long_dest_override = (i[2:1] == 2'd2);
      in_ctrl_store = i[0];
      #1 check("priv", 16'(force_privileged), 16'(i[0]));
      in_ctrl_store = 1'b0;
      @(posedge sys_clk);
      #1 check("page", 16'(page_select_n), 16'(i[0] ^ (i[2:1] == 0)));
    end
    mem_cycle = 1'b0;
    in_ctrl_store = 1'b0;
  endtask : t_page

  task automatic t_proto;
    logic [15:0] rd;
    logic f;
    int n;
    do_reset(1'b0, 1'b1, MSAC_MODE_PROTO);
    wait_n = 4'h1;
    acc(1'b1, 1'b0, 16'h0800, 16'hbeef, rd, f, n);
    acc(1'b0, 1'b0, 16'h0800, 16'h0, rd, f, n);
    check("proto_rd", rd, 16'hbeef);
    acc(1'b0, 1'b0, 16'h0bfe, 16'h0, rd, f, n);
    check("proto_hi", rd, 16'h1234);
    acc(1'b1, 1'b0, 16'h0000, 16'h5a5a, rd, f, n);
    check("proto_lat", 16'(n), 16'h1);
  endtask : t_proto

  task automatic t_base;
    logic [15:0] rd;
    logic f;
    int n;
    do_reset(1'b0, 1'b0, MSAC_MODE_BASE);
    acc(1'b0, 1'b0, 16'h0000, 16'h0, rd, f, n);
    check("base_ram", 16'(f), 16'h1);
    acc(1'b1, 1'b0, 16'h1000, 16'h0, rd, f, n);
    check("base_ext", 16'(f), 16'h1);
    @(posedge sys_clk);
    #1 undef_opcode = 1'b1;
    @(posedge sys_clk);
    #1 undef_opcode = 1'b0;
    check("trap", 16'(trap_req), 16'h1);
    check("level", 16'(trap_level), 16'h2);
    @(posedge sys_clk);
    #1 check("trap_end", 16'(trap_req), 16'h0);
    check("illegal_op_flag", 16'(illegal_op_flag), 16'h1);
    attached_proc_present_n = 1'b1;
    repeat (6) @(posedge sys_clk);
    #1 check("mode_up", 16'(mode), 16'(MSAC_MODE_PROTO));
  endtask : t_base

  task automatic give_verdict;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  // Main sequence, inputs quiet at time zero
  initial begin
    resetn = 1'b0;
    req = '0;
    {in_ctrl_store, mem_cycle, page_status_bit, undef_opcode} = 4'h0;
    {long_source_override, long_dest_override} = 2'b00;
    attached_proc_present_n = 1'b1;
    wait_n = 4'h0;
    t_std();
    t_page();
    t_proto();
    t_base();
    give_verdict();
  end

  // Whole run needs well under 1000 cycles; 100 us is ample
  initial begin
    #100us;
    num_errors++;
    give_verdict();
  end
endmodule : msac_access_ctrl_tb
